// ==== src/irq_req_pkg.sv ====
package irq_req_pkg;
  // ----------------------------------------
  // Interrupt numbers
  // ----------------------------------------
  localparam int NUM_W = 4;
  localparam int NUM_CNT = 16;
  localparam logic [NUM_W-1:0] NUM_EXT = 4'h0;
  localparam logic [NUM_W-1:0] NUM_FILT = 4'h1;
  localparam logic [NUM_W-1:0] NUM_CMP = 4'h2;
  localparam logic [NUM_W-1:0] NUM_CAP_OVF = 4'h3;
  localparam logic [NUM_W-1:0] NUM_CAP_MATCH = 4'h4;
  localparam logic [NUM_W-1:0] NUM_PWM_LAST = 4'h5;
  localparam int NUM_MF_BASE = 6;
  localparam int MF_CNT = 7;
  localparam int MF_PWM = 1;
  localparam int PWM_SRC = 4;
  // ----------------------------------------
  // Edge control encoding
  // ----------------------------------------
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] REG_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] REG_PRIO_EN = 6'h04;
  localparam logic [ADDR_W-1:0] REG_PRIO_FLAG = 6'h08;
  localparam logic [ADDR_W-1:0] REG_PWM_FLAG = 6'h0C;
  localparam logic [ADDR_W-1:0] REG_PWM_EN = 6'h10;
  localparam logic [ADDR_W-1:0] REG_SLOT_LO = 6'h14;
  localparam logic [ADDR_W-1:0] REG_SLOT_HI = 6'h18;
  localparam logic [ADDR_W-1:0] REG_EVT_STAT = 6'h1C;
  localparam logic [ADDR_W-1:0] REG_EVT_MASK = 6'h20;
  localparam logic [ADDR_W-1:0] REG_LAST_VEC = 6'h24;
  localparam logic [63:0] SLOT_RESET = 64'hFEDC_BA98_7654_3210;
  // Event status bits
  localparam int EVT_CALL = 0;
  localparam int EVT_STALL = 1;
  localparam int EVT_W = 2;
  // ----------------------------------------
  // Control register layout
  // ----------------------------------------
  typedef struct packed {
    logic filt_pull_high;
    logic filt_is_input;
    logic filt_pin_sel;
    logic ext_pull_high;
    logic ext_is_input;
    logic ext_pin_sel;
    logic [1:0] filter_edge_ctrl;
    logic [1:0] ext_edge_ctrl;
    logic global_irq_enable;
  } ctrl_t;
  localparam int CTRL_W = 11;
  // Vector call handed to the core sequencer
  typedef struct packed {
    logic valid;
    logic [NUM_W-1:0] num;
  } vec_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALL = 2'b01
  } call_st_t;
endpackage

// ==== src/irq_source_request_logic.sv ====
module irq_source_request_logic
  import irq_req_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [irq_req_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic ext_irq_pin_in,
  input wire logic filtered_irq_pin_in,
  input wire logic cmp0_out_in,
  input wire logic capture_overflow_irq_in,
  input wire logic capture_match_irq_in,
  input wire logic pwm_period_irq_in,
  input wire logic [2:0] pwm_duty_irq_in,
  input wire logic pwm_duty_last_irq_in,
  input wire logic [irq_req_pkg::MF_CNT-1:0] mf_event_in,
  input wire logic stack_full_in,
  input wire logic reti_in,
  output irq_req_pkg::vec_t vector_out,
  output logic global_irq_enable_out,
  output logic ext_pull_high_out,
  output logic filt_pull_high_out,
  output logic irq_out
);
  import irq_req_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Edge match for a two-bit edge field
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    logic rise;
    logic fall;
    rise = cur & ~prev;
    fall = prev & ~cur;
    case (sel)
      EDGE_RISE: edge_hit = rise;
      EDGE_FALL: edge_hit = fall;
      EDGE_BOTH: edge_hit = rise | fall;
      default: edge_hit = 1'b0;
    endcase
  endfunction

  // Byte-enable merge of a write into a register word
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    be_merge = res;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  ctrl_t ctrl_q;
  logic [NUM_CNT-1:0] prio_enable_bit_q;
  logic [NUM_CNT-1:0] prio_request_flag_q;
  logic [PWM_SRC-1:0] pwm_req_flag_q;
  logic [PWM_SRC-1:0] pwm_irq_en_q;
  logic [63:0] slot_q;
  logic [EVT_W-1:0] evt_stat_q;
  logic [EVT_W-1:0] evt_mask_q;
  logic wait_q;
  logic [2:0] ext_sync_q;
  logic [2:0] filt_sync_q;
  logic [2:0] cmp_sync_q;
  call_st_t st_q;
  vec_t vec_q;

  // Bus strobes
  logic wr_go;
  logic rd_go;
  logic [31:0] wmask;
  assign wr_go = avs_write_in & ~wait_q;
  assign rd_go = avs_read_in & wait_q;
  assign wmask = be_merge(32'h0000_0000, 32'hFFFF_FFFF, avs_byteenable_in);

  // ----------------------------------------
  // Avalon-MM slave: one wait cycle per access
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wait_q <= 1'b1;
    end
    else
    begin
      wait_q <= ~((avs_read_in | avs_write_in) & wait_q);
    end
  end

  // Read data captured in the wait cycle
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      avs_readdata_out <= 32'h0000_0000;
    end
    else if (rd_go)
    begin
      case (avs_address_in)
        REG_CTRL: avs_readdata_out <= 32'(ctrl_q);
        REG_PRIO_EN: avs_readdata_out <= 32'(prio_enable_bit_q);
        REG_PRIO_FLAG: avs_readdata_out <= 32'(prio_request_flag_q);
        REG_PWM_FLAG: avs_readdata_out <= 32'(pwm_req_flag_q);
        REG_PWM_EN: avs_readdata_out <= 32'(pwm_irq_en_q);
        REG_SLOT_LO: avs_readdata_out <= slot_q[31:0];
        REG_SLOT_HI: avs_readdata_out <= slot_q[63:32];
        REG_EVT_STAT: avs_readdata_out <= 32'(evt_stat_q);
        REG_EVT_MASK: avs_readdata_out <= 32'(evt_mask_q);
        REG_LAST_VEC: avs_readdata_out <= 32'(vec_q.num);
        default: avs_readdata_out <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_waitrequest_out = wait_q;

  // ----------------------------------------
  // Plain software registers
  // ----------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      prio_enable_bit_q <= '0;
      pwm_irq_en_q <= '0;
      slot_q <= SLOT_RESET;
      evt_mask_q <= '0;
    end
    else if (wr_go)
    begin
      case (avs_address_in)
        REG_PRIO_EN: prio_enable_bit_q <= NUM_CNT'(be_merge(32'(prio_enable_bit_q), avs_writedata_in, avs_byteenable_in));
        REG_PWM_EN: pwm_irq_en_q <= PWM_SRC'(be_merge(32'(pwm_irq_en_q), avs_writedata_in, avs_byteenable_in));
        REG_SLOT_LO: slot_q[31:0] <= be_merge(slot_q[31:0], avs_writedata_in, avs_byteenable_in);
        REG_SLOT_HI: slot_q[63:32] <= be_merge(slot_q[63:32], avs_writedata_in, avs_byteenable_in);
        REG_EVT_MASK: evt_mask_q <= EVT_W'(be_merge(32'(evt_mask_q), avs_writedata_in, avs_byteenable_in));
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Control register and global enable
  // ----------------------------------------
  logic call_go;
  logic [NUM_W-1:0] pick_num;
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ctrl_q <= '0;
    end
    else
    begin
      if (wr_go && avs_address_in == REG_CTRL)
      begin
        ctrl_q <= ctrl_t'(CTRL_W'(be_merge(32'(ctrl_q), avs_writedata_in, avs_byteenable_in)));
      end
      if (reti_in)
      begin
        ctrl_q.global_irq_enable <= 1'b1;
      end
      if (call_go)
      begin
        ctrl_q.global_irq_enable <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Pin and comparator synchronisers
  // ----------------------------------------
  // Two stages, third for edge history
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      ext_sync_q <= '0;
      filt_sync_q <= '0;
      cmp_sync_q <= '0;
    end
    else
    begin
      ext_sync_q <= {ext_sync_q[1:0], ext_irq_pin_in};
      filt_sync_q <= {filt_sync_q[1:0], filtered_irq_pin_in};
      cmp_sync_q <= {cmp_sync_q[1:0], cmp0_out_in};
    end
  end

  // ----------------------------------------
  // Source events
  // ----------------------------------------
  logic ext_qual;
  logic filt_qual;
  logic [NUM_CNT-1:0] set_vec;
  logic [NUM_CNT-1:0] clr_vec;
  logic [MF_CNT-1:0] mf_set;
  logic [PWM_SRC-1:0] pwm_evt;
  assign ext_qual = prio_enable_bit_q[NUM_EXT] & ctrl_q.ext_pin_sel & ctrl_q.ext_is_input;
  // Filtered pin routed, input and enabled
  assign filt_qual = prio_enable_bit_q[NUM_FILT] & ctrl_q.filt_pin_sel & ctrl_q.filt_is_input;
  // Period and duty 0-2 feed group 1
  assign pwm_evt = {pwm_duty_irq_in, pwm_period_irq_in};

  // Group requests, PWM gated by source enables
  always_comb
  begin
    mf_set = mf_event_in;
    // Grouped PWM needs its own enable
    mf_set[MF_PWM] = mf_event_in[MF_PWM] | (|(pwm_evt & pwm_irq_en_q));
  end

  always_comb
  begin
    set_vec = '0;
    set_vec[NUM_EXT] = ext_qual & edge_hit(ctrl_q.ext_edge_ctrl, ext_sync_q[2], ext_sync_q[1]);
    set_vec[NUM_FILT] = filt_qual & edge_hit(ctrl_q.filter_edge_ctrl, filt_sync_q[2], filt_sync_q[1]);
    set_vec[NUM_CMP] = cmp_sync_q[2] ^ cmp_sync_q[1];
    set_vec[NUM_CAP_OVF] = capture_overflow_irq_in;
    set_vec[NUM_CAP_MATCH] = capture_match_irq_in;
    set_vec[NUM_PWM_LAST] = pwm_duty_last_irq_in;
    // Group numbers follow the single sources
    // Any grouped source but a disabled PWM one sets its group
    set_vec[NUM_MF_BASE +: MF_CNT] = mf_set;
  end

  // Clears from software and from servicing
  always_comb
  begin
    clr_vec = '0;
    if (wr_go && avs_address_in == REG_PRIO_FLAG)
    begin
      clr_vec = NUM_CNT'(avs_writedata_in & wmask);
    end
    // Serviced flag dropped, the number being called now
    if (call_go)
    begin
      clr_vec[pick_num] = 1'b1;
    end
  end

  // ----------------------------------------
  // Request flags
  // ----------------------------------------
  // Flags hold regardless of global enable; set beats clear
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      prio_request_flag_q <= '0;
    end
    else
    begin
      prio_request_flag_q <= (prio_request_flag_q & ~clr_vec) | set_vec;
    end
  end

  // PWM source flags set on match, cleared only by software
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pwm_req_flag_q <= '0;
    end
    else if (wr_go && avs_address_in == REG_PWM_FLAG)
    begin
      pwm_req_flag_q <= (pwm_req_flag_q & ~PWM_SRC'(avs_writedata_in & wmask)) | pwm_evt;
    end
    else
    begin
      pwm_req_flag_q <= pwm_req_flag_q | pwm_evt;
    end
  end

  // ----------------------------------------
  // Slot order and vector call
  // ----------------------------------------
  logic [NUM_CNT-1:0] ready;
  logic pick_ok;
  assign ready = prio_request_flag_q & prio_enable_bit_q;

  always_comb
  begin
    pick_ok = 1'b0;
    pick_num = '0;
    for (int s = NUM_CNT - 1; s >= 0; s--)
    begin
      if (ready[slot_q[s*NUM_W +: NUM_W]])
      begin
        pick_ok = 1'b1;
        pick_num = slot_q[s*NUM_W +: NUM_W];
      end
    end
  end

  assign call_go = (st_q == ST_IDLE) & pick_ok & ctrl_q.global_irq_enable & ~stack_full_in;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st_q <= ST_IDLE;
      vec_q <= '0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          vec_q.valid <= call_go;
          vec_q.num <= call_go ? pick_num : vec_q.num;
          st_q <= call_go ? ST_CALL : ST_IDLE;
        end
        ST_CALL:
        begin
          vec_q.valid <= 1'b0;
          st_q <= ST_IDLE;
        end
        default:
        begin
          vec_q.valid <= 1'b0;
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Event status, mask and interrupt line
  // ----------------------------------------
  logic [EVT_W-1:0] evt_set;
  assign evt_set = {pick_ok & ctrl_q.global_irq_enable & stack_full_in, call_go};
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      evt_stat_q <= '0;
      irq_out <= 1'b0;
    end
    else
    begin
      if (wr_go && avs_address_in == REG_EVT_STAT)
      begin
        evt_stat_q <= (evt_stat_q & ~EVT_W'(avs_writedata_in & wmask)) | evt_set;
      end
      else
      begin
        evt_stat_q <= evt_stat_q | evt_set;
      end
      irq_out <= |(evt_stat_q & evt_mask_q);
    end
  end

  // Registered side outputs
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      global_irq_enable_out <= 1'b0;
      ext_pull_high_out <= 1'b0;
      filt_pull_high_out <= 1'b0;
    end
    else
    begin
      global_irq_enable_out <= ctrl_q.global_irq_enable;
      ext_pull_high_out <= ctrl_q.ext_pull_high;
      filt_pull_high_out <= ctrl_q.filt_pull_high;
    end
  end

  assign vector_out = vec_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  ext_rise_set_a: assert property (ext_qual && ctrl_q.ext_edge_ctrl == EDGE_RISE && ext_sync_q[1] && !ext_sync_q[2]
    |=> prio_request_flag_q[NUM_EXT]) else $error("external rising edge lost");
  ext_edge_off_a: assert property (ctrl_q.ext_edge_ctrl == EDGE_OFF && !prio_request_flag_q[NUM_EXT]
    |=> !prio_request_flag_q[NUM_EXT]) else $error("disabled external pin set flag");
  ext_unqual_a: assert property (!ext_qual && !prio_request_flag_q[NUM_EXT]
    |=> !prio_request_flag_q[NUM_EXT]) else $error("unrouted external pin set flag");
  pull_high_a: assert property (ext_pull_high_out == $past(ctrl_q.ext_pull_high))
    else $error("pull-high output wrong");
  filt_fall_a: assert property (filt_qual && ctrl_q.filter_edge_ctrl == EDGE_FALL && filt_sync_q[2] && !filt_sync_q[1]
    |=> prio_request_flag_q[NUM_FILT]) else $error("filtered falling edge lost");
  filt_unqual_a: assert property (!filt_qual && !prio_request_flag_q[NUM_FILT]
    |=> !prio_request_flag_q[NUM_FILT]) else $error("unrouted filtered pin set flag");
  cmp_change_a: assert property ($changed(cmp_sync_q[1]) |=> prio_request_flag_q[NUM_CMP])
    else $error("comparator change lost");
  cap_ovf_a: assert property (capture_overflow_irq_in |=> prio_request_flag_q[NUM_CAP_OVF])
    else $error("capture overflow lost");
  mf_group_a: assert property (|mf_event_in |=> |prio_request_flag_q[NUM_MF_BASE +: MF_CNT])
    else $error("group request lost");
  call_cond_a: assert property ($rose(vector_out.valid) |-> $past(ctrl_q.global_irq_enable) && !$past(stack_full_in)
    && $past(ready[pick_num]) && vector_out.num == $past(pick_num)) else $error("call without conditions");
  service_clear_a: assert property ($rose(vector_out.valid) |-> !ctrl_q.global_irq_enable
    ##1 !global_irq_enable_out) else $error("service kept global enable");
  pwm_flag_a: assert property (pwm_period_irq_in |=> pwm_req_flag_q[0])
    else $error("pwm period flag lost");
  flag_hold_a: assert property (prio_request_flag_q[NUM_CAP_MATCH] && !clr_vec[NUM_CAP_MATCH]
    |=> prio_request_flag_q[NUM_CAP_MATCH]) else $error("pending flag dropped");

  call_seen_c: cover property (vector_out.valid);
  stall_seen_c: cover property (pick_ok && ctrl_q.global_irq_enable && stack_full_in);
  pwm_call_c: cover property (pwm_evt[0] && pwm_irq_en_q[0] ##[1:20] vector_out.valid);
endmodule

// ==== test/core_model.sv ====
module core_model
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic call_in,
  input wire logic full_req_in,
  output logic stack_full_out,
  output logic reti_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Routine length before the return pulse
  localparam logic [7:0] RET_DLY = 8'h18;
  logic [7:0] cnt_q;
  // Stack level follows the bench request
  always_ff @(posedge clk_in)
  begin
    stack_full_out <= rst_in ? 1'b0 : full_req_in;
  end
  // Routine runs a fixed span, then returns once
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      cnt_q <= 8'h00;
    else if (call_in)
      cnt_q <= RET_DLY;
    else if (cnt_q != 8'h00)
      cnt_q <= cnt_q - 8'h01;
    reti_out <= !rst_in && (cnt_q == 8'h01);
  end
endmodule

// ==== test/test_irq_source_request_logic.sv ====
module test_irq_source_request_logic;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_req_pkg::*;
  logic clk_in, rst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [ADDR_W-1:0] avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [3:0] avs_byteenable_in;
  logic ext_irq_pin_in, filtered_irq_pin_in, cmp0_out_in, capture_overflow_irq_in;
  logic capture_match_irq_in, pwm_period_irq_in, pwm_duty_last_irq_in, stack_full_in, reti_in;
  logic [2:0] pwm_duty_irq_in;
  logic [MF_CNT-1:0] mf_event_in;
  vec_t vector_out;
  logic global_irq_enable_out, ext_pull_high_out, filt_pull_high_out, irq_out, full_req;
  int n_fail = 0;
  int cmp_count = 0;
  int call_cnt = 0;

  irq_source_request_logic DUT (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .ext_irq_pin_in(ext_irq_pin_in),
    .filtered_irq_pin_in(filtered_irq_pin_in), .cmp0_out_in(cmp0_out_in),
    .capture_overflow_irq_in(capture_overflow_irq_in), .capture_match_irq_in(capture_match_irq_in),
    .pwm_period_irq_in(pwm_period_irq_in), .pwm_duty_irq_in(pwm_duty_irq_in),
    .pwm_duty_last_irq_in(pwm_duty_last_irq_in), .mf_event_in(mf_event_in), .stack_full_in(stack_full_in),
    .reti_in(reti_in), .vector_out(vector_out), .global_irq_enable_out(global_irq_enable_out),
    .ext_pull_high_out(ext_pull_high_out), .filt_pull_high_out(filt_pull_high_out), .irq_out(irq_out));
  core_model core (.clk_in(clk_in), .rst_in(rst_in), .call_in(vector_out.valid), .full_req_in(full_req),
    .stack_full_out(stack_full_in), .reti_out(reti_in));

  // Clock and call counter
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    if (vector_out.valid === 1'b1)
      call_cnt++;
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Avalon access held until waitrequest is sampled low
  task automatic bus(input bit we, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    avs_address_in <= a;
    avs_writedata_in <= d;
    if (we)
      avs_write_in <= 1'b1;
    else
      avs_read_in <= 1'b1;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0 && n < 20)
    begin
      @(posedge clk_in);
      n++;
    end
    chk(n < 20, 1);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, exp);
  endtask
  task automatic set_pin(input bit f, input logic v);
    if (f)
      filtered_irq_pin_in <= v;
    else
      ext_irq_pin_in <= v;
    tick(6);
  endtask
  task automatic pwm_pulse(input int i);
    if (i == 0)
      pwm_period_irq_in <= 1'b1;
    else
      pwm_duty_irq_in[i-1] <= 1'b1;
    tick(1);
    pwm_period_irq_in <= 1'b0;
    pwm_duty_irq_in <= 3'h0;
    tick(2);
  endtask
  // Wait for a call, check its number and the dropped enable
  task automatic wait_call(input logic [3:0] num);
    int n;
    n = 0;
    while (vector_out.valid !== 1'b1 && n < 40)
    begin
      @(posedge clk_in);
      n++;
    end
    chk(n < 40, 1);
    chk(vector_out.num, num);
    @(posedge clk_in);
    chk(global_irq_enable_out, 0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_chk(REG_SLOT_LO, SLOT_RESET[31:0]);
    rd_chk(REG_SLOT_HI, SLOT_RESET[63:32]);
    rd_chk(REG_PRIO_FLAG, 32'h0000_0000);
    wr(REG_SLOT_HI, 32'h0123_4567);
    rd_chk(REG_SLOT_HI, 32'h0123_4567);
    wr(REG_SLOT_HI, SLOT_RESET[63:32]);
    wr(6'h28, 32'hFFFF_FFFF);
    rd_chk(6'h28, 32'h0000_0000);
    wr(REG_PRIO_EN, 32'h0000_FFFF);
  endtask
  task automatic t_pin(input bit f);
    ctrl_t c;
    c = '0;
    c.ext_pin_sel = 1'b1;
    c.ext_is_input = 1'b1;
    c.ext_pull_high = 1'b1;
    c.filt_pin_sel = 1'b1;
    c.filt_is_input = 1'b1;
    c.filt_pull_high = 1'b1;
    for (int e = 0; e < 4; e++)
    begin
      c.ext_edge_ctrl = 2'(e);
      c.filter_edge_ctrl = 2'(e);
      wr(REG_CTRL, 32'(c));
      set_pin(f, 1'b1);
      rd_chk(REG_PRIO_FLAG, 32'(e % 2) << f);
      wr(REG_PRIO_FLAG, 32'h0000_FFFF);
      set_pin(f, 1'b0);
      rd_chk(REG_PRIO_FLAG, 32'(e / 2) << f);
      wr(REG_PRIO_FLAG, 32'h0000_FFFF);
    end
    chk({ext_pull_high_out, filt_pull_high_out}, 2'b11);
    c.ext_pin_sel = 1'b0;
    c.filt_pin_sel = 1'b0;
    wr(REG_CTRL, 32'(c));
    set_pin(f, 1'b1);
    set_pin(f, 1'b0);
    rd_chk(REG_PRIO_FLAG, 32'h0000_0000);
  endtask
  task automatic t_sources();
    cmp0_out_in <= 1'b1;
    capture_overflow_irq_in <= 1'b1;
    tick(1);
    capture_overflow_irq_in <= 1'b0;
    tick(5);
    rd_chk(REG_PRIO_FLAG, 32'h0000_000C);
    wr(REG_PRIO_FLAG, 32'h0000_0004);
    cmp0_out_in <= 1'b0;
    capture_match_irq_in <= 1'b1;
    pwm_duty_last_irq_in <= 1'b1;
    tick(1);
    capture_match_irq_in <= 1'b0;
    pwm_duty_last_irq_in <= 1'b0;
    for (int g = 0; g < MF_CNT; g++)
    begin
      mf_event_in <= 7'(1 << g);
      tick(1);
    end
    mf_event_in <= 7'h00;
    tick(6);
    rd_chk(REG_PRIO_FLAG, 32'h0000_1FFC);
    chk(call_cnt, 0);
    wr(REG_PRIO_FLAG, 32'h0000_FFFF);
  endtask
  task automatic t_call();
    wr(REG_PRIO_EN, 32'h0000_0010);
    full_req <= 1'b1;
    wr(REG_CTRL, 32'h0000_0001);
    capture_match_irq_in <= 1'b1;
    tick(1);
    capture_match_irq_in <= 1'b0;
    tick(8);
    chk(call_cnt, 0);
    rd_chk(REG_PRIO_FLAG, 32'h0000_0010);
    full_req <= 1'b0;
    wait_call(NUM_CAP_MATCH);
    rd_chk(REG_PRIO_FLAG, 32'h0000_0000);
    capture_overflow_irq_in <= 1'b1;
    tick(1);
    capture_overflow_irq_in <= 1'b0;
    tick(30);
    chk(global_irq_enable_out, 1);
    chk(call_cnt, 1);
    rd_chk(REG_PRIO_FLAG, 32'h0000_0008);
    wr(REG_CTRL, 32'h0000_0000);
    wr(REG_PRIO_FLAG, 32'h0000_FFFF);
  endtask
  task automatic t_evt();
    rd_chk(REG_EVT_STAT, 32'h0000_0003);
    wr(REG_EVT_MASK, 32'h0000_0000);
    tick(1);
    chk(irq_out, 0);
    wr(REG_EVT_MASK, 32'h0000_0001);
    tick(1);
    chk(irq_out, 1);
    wr(REG_EVT_STAT, 32'h0000_0003);
    tick(1);
    chk(irq_out, 0);
  endtask
  task automatic t_pwm();
    for (int i = 0; i < 4; i++)
    begin
      wr(REG_PWM_EN, 32'(i % 2) << i);
      pwm_pulse(i);
      rd_chk(REG_PWM_FLAG, 32'h1 << i);
      rd_chk(REG_PRIO_FLAG, 32'(i % 2) << 7);
      wr(REG_PWM_FLAG, 32'h0000_000F);
      wr(REG_PRIO_FLAG, 32'h0000_FFFF);
    end
    wr(REG_PRIO_EN, 32'h0000_0080);
    wr(REG_PWM_EN, 32'h0000_0002);
    pwm_pulse(1);
    wr(REG_CTRL, 32'h0000_0001);
    wait_call(4'(NUM_MF_BASE + MF_PWM));
    rd_chk(REG_LAST_VEC, 32'h0000_0007);
    rd_chk(REG_PWM_FLAG, 32'h0000_0002);
    wr(REG_PWM_FLAG, 32'h0000_000F);
    rd_chk(REG_PWM_FLAG, 32'h0000_0000);
  endtask

  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    clk_in = 1'b0;
    rst_in = 1'b1;
    {avs_read_in, avs_write_in, ext_irq_pin_in, filtered_irq_pin_in, cmp0_out_in} = '0;
    {capture_overflow_irq_in, capture_match_irq_in, pwm_period_irq_in, pwm_duty_last_irq_in} = '0;
    avs_address_in = '0;
    avs_writedata_in = '0;
    avs_byteenable_in = 4'hF;
    pwm_duty_irq_in = '0;
    mf_event_in = '0;
    full_req = 1'b0;
    tick(6);
    rst_in <= 1'b0;
    tick(1);
    t_reset();
    t_pin(1'b0);
    t_pin(1'b1);
    t_sources();
    t_call();
    t_evt();
    t_pwm();
    conclude();
  end
  initial
  begin
    tick(20000);
    n_fail++;
    conclude();
  end
endmodule
